// *** design/hacps_pll_decode.sv ***
/*
  decode of the core pll configuration field into bypass, ratio and vco divider.
  assumes field bits are numbered as printed: bit 0 left, bit 6 right.
*/
`default_nettype none
module hacps_pll_decode
  import hacps_pkg::*;
(
  input wire logic [0:HACPS_CORE_FIELD_W-1] coreField,
  output logic bypass,
  output hacps_ratio_t ratio,
  output logic [3:0] vcoDiv,
  output logic reserved
);
  always_comb begin
    bypass = 1'b0;
    ratio = HACPS_RATIO_RSVD;
    reserved = 1'b0;
    vcoDiv = 4'h0;
    case (coreField[2:5])
      4'h0: begin
        bypass = 1'b1; // see R7
        ratio = HACPS_RATIO_BYPASS;
      end
      4'h1: ratio = coreField[6] ? HACPS_RATIO_1_5 : HACPS_RATIO_1_1; // see R8
      4'h2: ratio = coreField[6] ? HACPS_RATIO_2_5 : HACPS_RATIO_2_1; // see R8
      4'h3: begin
        ratio = coreField[6] ? HACPS_RATIO_RSVD : HACPS_RATIO_3_1; // see R8
        reserved = coreField[6]; // see R11
      end
      default: reserved = 1'b1; // see R11
    endcase
    // divider has no meaning while the pll is bypassed
    if (!bypass) begin
      case (coreField[0:1])
        2'b00: vcoDiv = 4'h2; // see R9
        2'b01: vcoDiv = 4'h4; // see R9
        default: vcoDiv = 4'h8; // see R9
      endcase
    end
  end
endmodule : hacps_pll_decode
`default_nettype wire

// *** design/hacps_sync.sv ***
/*
  two-flop synchroniser for a group of unrelated pin levels.
  assumes each bit is a slow level or a clock well below half the system rate.
*/
`default_nettype none
module hacps_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = pinIn;
    sync_d = meta_q;
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;
endmodule : hacps_sync
`default_nettype wire

// *** design/hacps_top.sv ***
/*
  host/agent clock selection, sync and bus clock output muxes, returned-clock
  lock supervision and core pll strap decode, with a small register port.
  assumes all clock and strap pins are asynchronous to clk and are sampled;
  output clocks are therefore rebuilt at the sampled rate, so input clocks must
  stay well below a quarter of the system clock for faithful edges.
*/
`default_nettype none
module hacps_top
  import hacps_pkg::*;
#(
  parameter int NUM_BUS_CLK = HACPS_NUM_BUS_CLK,
  parameter int LOCK_TIMEOUT = HACPS_LOCK_TIMEOUT,
  parameter int LOCK_EDGES = HACPS_LOCK_EDGES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic refClkIn,
  input wire logic busClkIn,
  input wire logic syncClkIn,
  input wire logic hostModeStrap,
  input wire logic syncDivStrap,
  input wire logic [HACPS_CORE_FIELD_W-1:0] corePllConfigField,
  input wire logic [HACPS_ADDR_W-1:0] regAddr,
  input wire logic [HACPS_DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [HACPS_DATA_W-1:0] regRdData,
  output logic syncClkOut,
  output logic [NUM_BUS_CLK-1:0] busClockOutputs,
  output logic csbTick,
  output logic locked,
  output logic hostMode,
  output logic corePllBypass,
  output hacps_ratio_t coreRatio,
  output logic [3:0] vcoDivider,
  output logic coreCfgReserved
);
  localparam int NSYNC = 5 + HACPS_CORE_FIELD_W;
  localparam int TOW = $clog2(LOCK_TIMEOUT + 1);
  localparam int EDW = $clog2(LOCK_EDGES + 1);
  localparam logic [TOW-1:0] TIMEOUT_MAX = TOW'(LOCK_TIMEOUT);
  localparam logic [EDW-1:0] EDGES_MAX = EDW'(LOCK_EDGES);

  typedef enum logic [1:0] {
    HACPS_ST_WAIT_STRAP,
    HACPS_ST_RUN
  } hacps_state_t;

  logic [NSYNC-1:0] pinSync;
  logic refS;
  logic busS;
  logic retS;
  logic hostS;
  logic divS;
  logic [HACPS_CORE_FIELD_W-1:0] fieldS;

  // every clock and strap pin passes two flops before anything looks at it
  hacps_sync #(
    .WIDTH(NSYNC)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn({corePllConfigField, syncDivStrap, hostModeStrap, syncClkIn, busClkIn, refClkIn}),
    .syncOut(pinSync)
  );

  always_comb begin
    refS = pinSync[0];
    busS = pinSync[1];
    retS = pinSync[2];
    hostS = pinSync[3];
    divS = pinSync[4];
    fieldS = pinSync[NSYNC-1:5];
  end

  // strap capture: taken once, two cycles after the synchroniser has settled
  hacps_state_t state_q;
  hacps_state_t state_d;
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic hostMode_q;
  logic hostMode_d;
  logic syncDiv_q;
  logic syncDiv_d;
  logic [HACPS_CORE_FIELD_W-1:0] field_q;
  logic [HACPS_CORE_FIELD_W-1:0] field_d;

  always_comb begin
    state_d = state_q;
    settle_d = settle_q;
    hostMode_d = hostMode_q;
    syncDiv_d = syncDiv_q;
    field_d = field_q;
    case (state_q)
      HACPS_ST_WAIT_STRAP: begin
        // the synchroniser still shows its reset zeros for two edges after release
        settle_d = settle_q + 2'h1;
        if (settle_q == 2'h3) begin
          hostMode_d = hostS;
          syncDiv_d = divS;
          field_d = fieldS;
          state_d = HACPS_ST_RUN;
        end
      end
      HACPS_ST_RUN: state_d = HACPS_ST_RUN;
      default: state_d = HACPS_ST_WAIT_STRAP;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= HACPS_ST_WAIT_STRAP;
      settle_q <= 2'h0;
      hostMode_q <= 1'b0;
      syncDiv_q <= 1'b0;
      field_q <= '0;
    end else begin
      state_q <= state_d;
      settle_q <= settle_d;
      hostMode_q <= hostMode_d;
      syncDiv_q <= syncDiv_d;
      field_q <= field_d;
    end
  end

  // primary clock, halving stage and output muxes
  logic running;
  logic primary;
  logic primPrev_q;
  logic primPrev_d;
  logic half_q;
  logic half_d;
  logic syncOut_q;
  logic syncOut_d;
  logic [NUM_BUS_CLK-1:0] busOut_q;
  logic [NUM_BUS_CLK-1:0] busOut_d;
  logic [NUM_BUS_CLK-1:0] output_clock_control_reg_q;
  logic [NUM_BUS_CLK-1:0] output_clock_control_reg_d;

  always_comb begin
    running = (state_q == HACPS_ST_RUN);
    // agent boards ground the reference pin, so it is never looked at there
    primary = hostMode_q ? refS : busS; // see R1 see R2
    primPrev_d = primary;
    half_d = half_q;
    if (!running) begin
      half_d = 1'b0;
    end else if (hacps_rise(primary, primPrev_q)) begin
      half_d = ~half_q; // see R3
    end
    syncOut_d = 1'b0;
    busOut_d = '0;
    if (running) begin
      syncOut_d = syncDiv_q ? half_q : primary; // see R4
      for (int i = 0; i < NUM_BUS_CLK; i++) begin
        busOut_d[i] = output_clock_control_reg_q[i] ? half_q : primary; // see R5
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      primPrev_q <= 1'b0;
      half_q <= 1'b0;
      syncOut_q <= 1'b0;
      busOut_q <= '0;
    end else begin
      primPrev_q <= primPrev_d;
      half_q <= half_d;
      syncOut_q <= syncOut_d;
      busOut_q <= busOut_d;
    end
  end

  // lock to the returned sync clock; a missing edge for too long drops lock
  logic retPrev_q;
  logic retPrev_d;
  logic retRise;
  logic [TOW-1:0] idle_q;
  logic [TOW-1:0] idle_d;
  logic [EDW-1:0] edges_q;
  logic [EDW-1:0] edges_d;
  logic locked_q;
  logic locked_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    retPrev_d = retS;
    retRise = hacps_rise(retS, retPrev_q);
    idle_d = idle_q;
    edges_d = edges_q;
    locked_d = locked_q;
    if (!running) begin
      idle_d = '0;
      edges_d = '0;
      locked_d = 1'b0;
    end else if (retRise) begin
      idle_d = '0;
      if (edges_q != EDGES_MAX) begin
        edges_d = edges_q + EDW'(1);
      end
      if (edges_q == EDGES_MAX - EDW'(1) || edges_q == EDGES_MAX) begin
        locked_d = 1'b1; // see R6
      end
    end else if (idle_q == TIMEOUT_MAX) begin
      // loop-back missing or broken on the board
      edges_d = '0;
      locked_d = 1'b0;
    end else begin
      idle_d = idle_q + TOW'(1);
    end
    // internal bus timing follows the returned clock, not our own output
    tick_d = running & retRise & locked_d; // see R6
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      retPrev_q <= 1'b0;
      idle_q <= '0;
      edges_q <= '0;
      locked_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      retPrev_q <= retPrev_d;
      idle_q <= idle_d;
      edges_q <= edges_d;
      locked_q <= locked_d;
      tick_q <= tick_d;
    end
  end

  // core pll strap decode, registered for the outputs
  logic decBypass;
  hacps_ratio_t decRatio;
  logic [3:0] decVco;
  logic decRsvd;
  logic bypass_q;
  logic bypass_d;
  hacps_ratio_t ratio_q;
  hacps_ratio_t ratio_d;
  logic [3:0] vco_q;
  logic [3:0] vco_d;
  logic rsvd_q;
  logic rsvd_d;
  logic [0:HACPS_CORE_FIELD_W-1] fieldPrt;

  // decoder counts bits from the left; index by index keeps port bit i as bit i
  always_comb begin
    for (int i = 0; i < HACPS_CORE_FIELD_W; i++) begin
      fieldPrt[i] = field_q[i];
    end
  end

  hacps_pll_decode u_dec (
    .coreField(fieldPrt),
    .bypass(decBypass),
    .ratio(decRatio),
    .vcoDiv(decVco),
    .reserved(decRsvd)
  );

  always_comb begin
    bypass_d = running & decBypass; // see R7
    ratio_d = running ? decRatio : HACPS_RATIO_BYPASS; // see R8
    vco_d = running ? decVco : 4'h0; // see R9
    rsvd_d = running & decRsvd; // see R11
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bypass_q <= 1'b0;
      ratio_q <= HACPS_RATIO_BYPASS;
      vco_q <= 4'h0;
      rsvd_q <= 1'b0;
    end else begin
      bypass_q <= bypass_d;
      ratio_q <= ratio_d;
      vco_q <= vco_d;
      rsvd_q <= rsvd_d;
    end
  end

  // register port: writes take effect next edge, read data stands one cycle
  logic [HACPS_DATA_W-1:0] rdData_q;
  logic [HACPS_DATA_W-1:0] rdData_d;
  logic [HACPS_DATA_W-1:0] status;

  always_comb begin
    status = '0;
    status[HACPS_ST_HOST_BIT] = hostMode_q;
    status[HACPS_ST_LOCK_BIT] = locked_q;
    status[HACPS_ST_BYPASS_BIT] = bypass_q;
    status[HACPS_ST_RSVD_BIT] = rsvd_q;
    status[HACPS_ST_SYNCDIV_BIT] = syncDiv_q;
    status[HACPS_ST_RATIO_LSB +: 3] = ratio_q;
    status[HACPS_ST_VCO_LSB +: 4] = vco_q;
    output_clock_control_reg_d = output_clock_control_reg_q;
    if (regWrite && regAddr == HACPS_OFS_OUT_CLK_CTRL) begin
      output_clock_control_reg_d = regWrData[NUM_BUS_CLK-1:0]; // see R5
    end
    rdData_d = '0;
    if (regRead) begin
      case (regAddr)
        HACPS_OFS_OUT_CLK_CTRL: rdData_d[NUM_BUS_CLK-1:0] = output_clock_control_reg_q;
        HACPS_OFS_STATUS: rdData_d = status;
        HACPS_OFS_CORE_CFG: rdData_d[HACPS_CORE_FIELD_W-1:0] = field_q;
        default: rdData_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      output_clock_control_reg_q <= NUM_BUS_CLK'(HACPS_OUT_CLK_CTRL_RST);
      rdData_q <= '0;
    end else begin
      output_clock_control_reg_q <= output_clock_control_reg_d;
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;
  assign syncClkOut = syncOut_q;
  assign busClockOutputs = busOut_q;
  assign csbTick = tick_q;
  assign locked = locked_q;
  assign hostMode = hostMode_q;
  assign corePllBypass = bypass_q;
  assign coreRatio = ratio_q;
  assign vcoDivider = vco_q;
  assign coreCfgReserved = rsvd_q;
endmodule : hacps_top
`default_nettype wire

// *** include/hacps_pkg.sv ***
/*
  constants, types and the rising-edge function shared by the clock select block.
  assumes one 25 MHz system clock, a synchronous active-low reset and a plain
  strobe register port with 32-bit data.
*/
// Notes on behaviour
// R1 - in host mode the reference clock pin is the primary source of the whole clock tree.
// R2 - in agent mode the bus clock pin is the primary source and the board grounds the reference pin.
// R3 - in host mode the primary clock feeds a halving stage and both rates reach the output muxes.
// R4 - a strap picks whether the sync clock output carries the full or the halved clock.
// R5 - each bus clock output has its own divide-select bit in the output clock control register.
// R6 - the sync output is looped back on the board and the internal timing locks to the return.
// R7 - core field bits 2 to 5 all zero means the core pll is off and bypassed, whatever else is set.
// R8 - bits 2 to 5 with bit 6 give the core to bus ratio: 1:1, 1.5:1, 2:1, 2.5:1 or 3:1.
// R9 - bits 0 to 1 pick the vco divider: 00 gives 2, 01 gives 4, 10 or 11 give 8.
// R10 - whoever straps the field keeps the resulting vco frequency inside its allowed window.
// R11 - any core field code outside the bypass and ratio codes is reserved and flagged as such.
`default_nettype none
package hacps_pkg;
  localparam int HACPS_DATA_W = 32;
  localparam int HACPS_ADDR_W = 8;
  localparam int HACPS_NUM_BUS_CLK = 5;
  localparam int HACPS_CORE_FIELD_W = 7;

  localparam logic [7:0] HACPS_OFS_OUT_CLK_CTRL = 8'h00;
  localparam logic [7:0] HACPS_OFS_STATUS = 8'h04;
  localparam logic [7:0] HACPS_OFS_CORE_CFG = 8'h08;

  localparam logic [4:0] HACPS_OUT_CLK_CTRL_RST = 5'h00;

  // status register field positions
  localparam int HACPS_ST_HOST_BIT = 0;
  localparam int HACPS_ST_LOCK_BIT = 1;
  localparam int HACPS_ST_BYPASS_BIT = 2;
  localparam int HACPS_ST_RSVD_BIT = 3;
  localparam int HACPS_ST_SYNCDIV_BIT = 4;
  localparam int HACPS_ST_RATIO_LSB = 8;
  localparam int HACPS_ST_VCO_LSB = 12;

  // lock supervision of the returned sync clock: timeout in system clock cycles, lock after this many return edges
  localparam int HACPS_LOCK_TIMEOUT = 64;
  localparam int HACPS_LOCK_EDGES = 4;

  typedef enum logic [2:0] {
    HACPS_RATIO_BYPASS,
    HACPS_RATIO_1_1,
    HACPS_RATIO_1_5,
    HACPS_RATIO_2_1,
    HACPS_RATIO_2_5,
    HACPS_RATIO_3_1,
    HACPS_RATIO_RSVD
  } hacps_ratio_t;

  function automatic logic hacps_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction : hacps_rise
endpackage : hacps_pkg
`default_nettype wire

// *** sim/hacps_clk_src.sv ***
/* board clock source and sync loop-back model for hacps_top.
   assumes the bench picks the mode and may cut or slow the return path. */
`default_nettype none
module hacps_clk_src (
  input wire logic agentMode,
  input wire logic cut,
  input wire logic slow,
  input wire logic syncOut,
  output logic refClk,
  output logic busClk,
  output logic syncRet
);
  timeunit 1ns;
  timeprecision 1ps;
  logic refRun = 1'b0;
  logic busRun = 1'b0;
  logic retQ = 1'b0;
  // a quarter-nanosecond phase keeps every reference and bus clock edge off the system clock edges
  initial begin
    #0.25;
    fork
      forever #330 refRun = ~refRun;
      forever #470 busRun = ~busRun;
    join
  end
  // reference pin grounded on an agent board
  assign refClk = agentMode ? 1'b0 : refRun;
  assign busClk = busRun;
  // one trace delay for every agent; slow stands for a long route
  always @(syncOut) retQ <= #(slow ? 230 : 30) syncOut;
  // a cut loop leaves the pin pulled low, so no edges return
  assign syncRet = cut ? 1'b0 : retQ;
endmodule : hacps_clk_src
`default_nettype wire

// *** sim/hacps_top_asserts.sv ***
/* port checker for hacps_top: strap decode, clock muxes, lock.
   assumes straps stay steady between resets. */
`default_nettype none
module hacps_top_asserts
  import hacps_pkg::*;
#(
  parameter int NUM_BUS_CLK = HACPS_NUM_BUS_CLK,
  parameter int LOCK_TIMEOUT = HACPS_LOCK_TIMEOUT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic refClkIn,
  input wire logic busClkIn,
  input wire logic syncClkIn,
  input wire logic hostModeStrap,
  input wire logic syncDivStrap,
  input wire logic [HACPS_CORE_FIELD_W-1:0] corePllConfigField,
  input wire logic [HACPS_ADDR_W-1:0] regAddr,
  input wire logic [HACPS_DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic syncClkOut,
  input wire logic [NUM_BUS_CLK-1:0] busClockOutputs,
  input wire logic csbTick,
  input wire logic locked,
  input wire logic hostMode,
  input wire logic corePllBypass,
  input wire hacps_ratio_t coreRatio,
  input wire logic [3:0] vcoDivider,
  input wire logic coreCfgReserved
);
  logic [3:0] runQ, runD, nib;
  logic [7:0] quietQ, quietD;
  logic [NUM_BUS_CLK-1:0] occrQ, occrD, occrLagQ;
  logic retQ, run, prim;
  logic [1:0] vsel;
  assign nib = {corePllConfigField[2], corePllConfigField[3], corePllConfigField[4],
    corePllConfigField[5]};
  assign vsel = {corePllConfigField[0], corePllConfigField[1]};
  assign run = runQ >= 4'hc;
  assign prim = hostModeStrap ? refClkIn : busClkIn;
  always_comb begin
    runD = (runQ == 4'hf) ? runQ : runQ + 4'h1;
    quietD = (syncClkIn && !retQ) ? 8'h00 : ((quietQ == 8'hff) ? quietQ : quietQ + 8'h01);
    occrD = (regWrite && regAddr == HACPS_OFS_OUT_CLK_CTRL) ? regWrData[NUM_BUS_CLK-1:0] : occrQ;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      runQ <= 4'h0;
      quietQ <= 8'h00;
      occrQ <= '0;
      occrLagQ <= '0;
      retQ <= 1'b0;
    end else begin
      runQ <= runD;
      quietQ <= quietD;
      occrQ <= occrD;
      occrLagQ <= occrQ;
      retQ <= syncClkIn;
    end
  end
  function automatic hacps_ratio_t expR(input logic [3:0] n, input logic h);
    case (n)
      4'h1: return h ? HACPS_RATIO_1_5 : HACPS_RATIO_1_1;
      4'h2: return h ? HACPS_RATIO_2_5 : HACPS_RATIO_2_1;
      4'h3: return h ? HACPS_RATIO_RSVD : HACPS_RATIO_3_1;
      default: return HACPS_RATIO_RSVD;
    endcase
  endfunction : expR
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  bypass_cause_a:
    assert property (run |-> corePllBypass == (nib == 4'h0)) else $error("bypass wrong");
  bypass_force_a:
    assert property (corePllBypass |-> coreRatio == HACPS_RATIO_BYPASS && vcoDivider == 4'h0
      && !coreCfgReserved) else $error("bypass outputs wrong");
  ratio_decode_a:
    assert property (run && !corePllBypass |-> coreRatio == expR(nib, corePllConfigField[6])
      && coreCfgReserved == (coreRatio == HACPS_RATIO_RSVD)) else $error("ratio wrong");
  vco_decode_a:
    assert property (run && !corePllBypass |-> vcoDivider == (vsel == 2'b00 ? 4'h2 :
      (vsel == 2'b01 ? 4'h4 : 4'h8))) else $error("vco divider wrong");
  sync_full_a:
    assert property (run |-> hostMode == hostModeStrap && (syncDivStrap ||
      syncClkOut == $past(prim, 3))) else $error("sync output wrong");
  sync_half_a:
    assert property (run && syncDivStrap |-> $changed(syncClkOut) == ($past(prim, 4)
      && !$past(prim, 5))) else $error("halved sync wrong");
  bus_full_a:
    assert property (run |-> ((busClockOutputs ^ {NUM_BUS_CLK{$past(prim, 3)}})
      & ~occrLagQ) == '0) else $error("full bus clock wrong");
  bus_half_a:
    assert property (run && syncDivStrap |-> ((busClockOutputs ^ {NUM_BUS_CLK{syncClkOut}})
      & occrLagQ) == '0) else $error("halved bus clock wrong");
  bus_half_edge_a:
    assert property (run && occrLagQ[0] && $past(occrLagQ[0]) |-> $changed(busClockOutputs[0])
      == ($past(prim, 4) && !$past(prim, 5))) else $error("halved bus edge wrong");
  lock_tick_a:
    assert property (csbTick || $rose(locked) |-> csbTick && locked && $past(syncClkIn, 3)
      && !$past(syncClkIn, 4)) else $error("lock tick wrong");
  lock_loss_a:
    assert property (int'(quietQ) >= LOCK_TIMEOUT + 6 |-> !locked) else $error("lock held");
  cover property ($rose(locked));
  cover property ($fell(locked));
  cover property (run && coreCfgReserved);
  cover property (run && corePllBypass);
endmodule : hacps_top_asserts
bind hacps_top hacps_top_asserts #(.NUM_BUS_CLK(NUM_BUS_CLK), .LOCK_TIMEOUT(LOCK_TIMEOUT))
  u_chk (.clk, .rst_n, .refClkIn, .busClkIn, .syncClkIn, .hostModeStrap, .syncDivStrap,
  .corePllConfigField, .regAddr, .regWrData, .regWrite, .syncClkOut, .busClockOutputs,
  .csbTick, .locked, .hostMode, .corePllBypass, .coreRatio, .vcoDivider, .coreCfgReserved);
`default_nettype wire

// *** sim/testbench.sv ***
/* self-checking bench for hacps_top: straps, register port, lock loss.
   assumes the clock source model and the bound port checker. */
`default_nettype none
module testbench
  import hacps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, hostModeStrap = 1'b0, syncDivStrap = 1'b0;
  logic regWrite = 1'b0, regRead = 1'b0, cut = 1'b0, slow = 1'b0, rdPend = 1'b0;
  logic [HACPS_CORE_FIELD_W-1:0] corePllConfigField = '0;
  logic [HACPS_ADDR_W-1:0] regAddr = '0;
  logic [HACPS_DATA_W-1:0] regWrData = '0;
  logic [HACPS_DATA_W-1:0] regRdData;
  logic refClkIn, busClkIn, syncClkIn, syncClkOut, csbTick, locked, hostMode;
  logic corePllBypass, coreCfgReserved;
  logic [HACPS_NUM_BUS_CLK-1:0] busClockOutputs;
  hacps_ratio_t coreRatio;
  logic [3:0] vcoDivider;
  logic [31:0] expQ[$], mskQ[$];
  int numErrors = 0, comparisons = 0, cycles = 0, seed = 32'h0216;
  always #20 clk = ~clk;
  hacps_top u_dut (.clk, .rst_n, .refClkIn, .busClkIn, .syncClkIn, .hostModeStrap,
    .syncDivStrap, .corePllConfigField, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .syncClkOut, .busClockOutputs, .csbTick, .locked, .hostMode, .corePllBypass, .coreRatio,
    .vcoDivider, .coreCfgReserved);
  hacps_clk_src u_src (.agentMode(!hostModeStrap), .cut, .slow, .syncOut(syncClkOut),
    .refClk(refClkIn), .busClk(busClkIn), .syncRet(syncClkIn));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("errors %0d comparisons %0d", numErrors, comparisons);
    if (numErrors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge clk);
    regRead <= 1'b0;
  endtask : rd
  function automatic logic [31:0] expSt(input logic h, input logic sd, input logic [3:0] n,
      input logic [1:0] v, input logic hf, input logic lk);
    hacps_ratio_t r;
    logic [3:0] dv;
    logic rs;
    dv = (v == 2'b00) ? 4'h2 : ((v == 2'b01) ? 4'h4 : 4'h8);
    rs = (n > 4'h3) || (n == 4'h3 && hf);
    case (n)
      4'h0: r = HACPS_RATIO_BYPASS;
      4'h1: r = hf ? HACPS_RATIO_1_5 : HACPS_RATIO_1_1;
      4'h2: r = hf ? HACPS_RATIO_2_5 : HACPS_RATIO_2_1;
      default: r = rs ? HACPS_RATIO_RSVD : HACPS_RATIO_3_1;
    endcase
    if (n == 4'h0) dv = 4'h0;
    return {16'h0, dv, 1'b0, r, 3'h0, sd, rs, n == 4'h0, lk, h};
  endfunction : expSt
  // read data stands only in the cycle after the strobe, zero otherwise
  always @(posedge clk) begin
    cycles++;
    if (rdPend) begin
      check(regRdData, expQ.pop_front());
    end else if (cycles > 1) begin
      check(regRdData, 32'h0);
    end
    rdPend <= regRead;
    if (cycles == 20000) begin
      numErrors++;
      finish_test();
    end
  end
  initial begin
    logic [3:0] nib;
    logic hf;
    logic [31:0] d;
    for (int k = 0; k < 12; k++) begin
      nib = 4'(k % 6);
      hf = k >= 6;
      d = $random(seed);
      @(posedge clk);
      rst_n <= 1'b0;
      hostModeStrap <= d[31];
      syncDivStrap <= d[30];
      slow <= d[29];
      // any divider code; keeping the vco in its window is the strap owner's job
      corePllConfigField <= {hf, nib[0], nib[1], nib[2], nib[3], d[8], d[9]};
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(HACPS_OFS_OUT_CLK_CTRL, 32'h0);
      wr(HACPS_OFS_OUT_CLK_CTRL, d);
      rd(HACPS_OFS_OUT_CLK_CTRL, d & 32'h1f);
      wr(8'h0c, d);
      rd(8'h0c, 32'h0);
      rd(HACPS_OFS_CORE_CFG, {25'h0, corePllConfigField});
      for (int i = 0; i < 400 && locked !== 1'b1; i++) @(posedge clk);
      rd(HACPS_OFS_STATUS, expSt(d[31], d[30], nib, d[9:8], hf, 1'b1));
      // the return path is cut to check that lock is dropped
      cut <= 1'b1;
      repeat (120) @(posedge clk);
      rd(HACPS_OFS_STATUS, expSt(d[31], d[30], nib, d[9:8], hf, 1'b0));
      cut <= 1'b0;
    end
    // let the last read data reach the watcher before closing
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
